// >>> logic/serial_net_pkg.sv
// Shared constants for the serial/network packing forwarder.
// Assumes a 10 MHz pclk and an APB master with 32-bit data.
package serial_net_pkg;
  // Clock and time
  localparam int CLK_NS = 100;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int MIN_MS = 60_000;
  // Sizes
  localparam int HOSTS = 8;
  localparam int BUF_BYTES = 1024;
  localparam int LEN_W = 11;
  localparam int HW = 16;
  localparam int ALIVE_W = 7;
  localparam int CONN_W = 4;
  localparam int CTRL_W = 10;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DELIM = 8'h04;
  localparam logic [7:0] OFS_PKTLEN = 8'h08;
  localparam logic [7:0] OFS_GAP = 8'h0C;
  localparam logic [7:0] OFS_ALIVE = 8'h10;
  localparam logic [7:0] OFS_RESPTO = 8'h14;
  localparam logic [7:0] OFS_MAXCONN = 8'h18;
  localparam logic [7:0] OFS_SERPARAM = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // Control register fields
  localparam int CTRL_CMD = 0;
  localparam int CTRL_JAM = 1;
  localparam int CTRL_HCTL = 2;
  localparam int CTRL_LDLOW = 3;
  localparam int CTRL_UNREQ = 4;
  localparam int CTRL_PROC = 6;
  localparam int CTRL_D1EN = 8;
  localparam int CTRL_D2EN = 9;
  // Reset values
  localparam logic [6:0] ALIVE_RST = 7'h07;
  localparam logic [3:0] MAXCONN_RST = 4'h1;
  localparam logic [3:0] MAXCONN_TOP = 4'h8;
  typedef enum logic [1:0] {
    DP_NONE = 2'b00, DP_PLUS1 = 2'b01, DP_PLUS2 = 2'b10, DP_STRIP = 2'b11
  } delim_proc_type;
  typedef enum logic [1:0] {
    UNREQ_DISCARD = 2'b00, UNREQ_LAST = 2'b01, UNREQ_ALL = 2'b10
  } unreq_type;
endpackage : serial_net_pkg

// >>> logic/pack_if.sv
// Packing settings and the millisecond tick passed to the packer.
// Assumes all members change only on pclk edges.
`timescale 1ns/100ps
interface pack_if;
  logic [10:0] pkt_len;
  logic [7:0] d1;
  logic [7:0] d2;
  logic d1_en;
  logic d2_en;
  serial_net_pkg::delim_proc_type proc;
  logic [15:0] gap_ms;
  logic ms_tick;
  modport cfg (output pkt_len, d1, d2, d1_en, d2_en, proc, gap_ms, ms_tick);
  modport packer (input pkt_len, d1, d2, d1_en, d2_en, proc, gap_ms, ms_tick);
endinterface : pack_if

// >>> logic/serial_packer.sv
// Packs serial receive bytes into network packets.
// Assumes settings through pack_if and a stallable consumer.
`timescale 1ns/100ps
module serial_packer #(
  parameter int BUF = serial_net_pkg::BUF_BYTES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Packing settings
  pack_if.packer cfg,
  // Serial receive bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Packed stream
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_flush,
  output logic out_empty,
  output logic [1:0] out_strip,
  input wire logic out_ready
);
  localparam logic [10:0] BUF_N = 11'(BUF);
  if (BUF < 1 || BUF > 2047) begin : g_bad_buf
    $error("serial_packer: BUF out of range");
  end
  typedef struct packed {
    logic [10:0] cnt;
    logic [1:0] tail;
    logic d1_seen;
    logic [15:0] idle;
    logic ov;
    logic [7:0] od;
    logic oflush;
    logic oempty;
    logic [1:0] ostrip;
  } pack_state_type;
  pack_state_type s;
  pack_state_type next_s;
  logic take;
  logic hit;
  logic flush;
  logic [10:0] cnt_n;
  assign rx_ready = !s.ov || out_ready;
  assign take = rx_valid && rx_ready;
  assign out_valid = s.ov;
  assign out_data = s.od;
  assign out_flush = s.oflush;
  assign out_empty = s.oempty;
  assign out_strip = s.ostrip;
  always_comb begin
    next_s = s;
    hit = 1'b0;
    flush = 1'b0;
    cnt_n = s.cnt + 11'd1;
    if (out_ready) begin
      next_s.ov = 1'b0;
      next_s.oflush = 1'b0;
      next_s.oempty = 1'b0;
      next_s.ostrip = 2'd0;
    end
    if (take) begin
      next_s.ov = 1'b1;
      next_s.od = rx_data;
      next_s.idle = 16'h0000;
      next_s.cnt = cnt_n;
      hit = cfg.d1_en && (cfg.d2_en ? (s.d1_seen && rx_data == cfg.d2)
                                    : rx_data == cfg.d1);
      next_s.d1_seen = cfg.d1_en && cfg.d2_en && rx_data == cfg.d1;
      if (s.tail != 2'd0) begin
        next_s.tail = s.tail - 2'd1;
        flush = (s.tail == 2'd1);
      end else if (hit) begin
        case (cfg.proc)
          serial_net_pkg::DP_NONE: flush = 1'b1;
          serial_net_pkg::DP_PLUS1: next_s.tail = 2'd1;
          serial_net_pkg::DP_PLUS2: next_s.tail = 2'd2;
          serial_net_pkg::DP_STRIP: begin
            flush = 1'b1;
            next_s.ostrip = cfg.d2_en ? 2'd2 : 2'd1;
          end
          default: flush = 1'b1;
        endcase
      end
      if (cfg.pkt_len != 11'd0 && cnt_n >= cfg.pkt_len) flush = 1'b1;
      if (cnt_n >= BUF_N) flush = 1'b1;
    end else if (cfg.ms_tick && s.cnt != 11'd0 && cfg.gap_ms != 16'h0000) begin
      if (s.idle != 16'hFFFF) next_s.idle = s.idle + 16'd1;
      if (next_s.idle >= cfg.gap_ms && !next_s.ov) begin
        flush = 1'b1;
        next_s.ov = 1'b1;
        next_s.oempty = 1'b1;
      end
    end
    if (flush) begin
      next_s.oflush = 1'b1;
      next_s.cnt = 11'd0;
      next_s.tail = 2'd0;
      next_s.d1_seen = 1'b0;
      next_s.idle = 16'h0000;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s <= '0;
    else s <= next_s;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pair;
    take && rx_data == cfg.d1 ##1 take && rx_data == cfg.d2;
  endsequence
  chk_len_flush: assert property (
    take && cfg.pkt_len != 11'd0 && s.cnt + 11'd1 == cfg.pkt_len
    |=> s.ov && s.oflush && s.cnt == 11'd0)
    else $error("length limit did not flush");
  chk_full_flush: assert property (
    take && s.cnt == BUF_N - 11'd1 |=> s.oflush)
    else $error("full buffer did not flush");
  chk_strip_count: assert property (
    take && hit && s.tail == 2'd0 && cfg.proc == serial_net_pkg::DP_STRIP
    |=> s.oflush && s.ostrip == (cfg.d2_en ? 2'd2 : 2'd1))
    else $error("strip count wrong");
  chk_pair_flush: assert property (
    cfg.d1_en && cfg.d2_en && cfg.proc == serial_net_pkg::DP_NONE &&
    s.tail == 2'd0 ##0 s_pair |=> s.oflush)
    else $error("delimiter pair did not flush");
  chk_gap_off: assert property (
    cfg.gap_ms == 16'h0000 |=> !(s.ov && s.oempty && !$past(s.oempty)))
    else $error("idle flush with gap disabled");
endmodule : serial_packer

// >>> logic/serial_net_forwarder.sv
// Per-port forwarder: packing, host sessions, command queue, APB registers.
// Assumes an APB master on pclk and host/serial events synchronous to pclk.
// How it works
// - Probe open hosts each minute; close after alive-time minutes unanswered.
// - Alive time zero: no probes and connections never time out.
// - A closed slot is free again for any host's new connection.
// - Limit one gives full control; two or more is a data tunnel.
// - Multi-host mode serves two to eight hosts with local serial settings.
// - Network data reaches the serial port in arrival order.
// - Without skipping, hold the next group until every host took it.
// - With skipping, busy hosts are left out and others continue.
// - Multi-host control commands ignored unless enabled; latest then wins.
// - Link-down low option drives RTS and DTR low without connections.
// - Commands queue in FIFO order, one outstanding per host.
// - Responses go to the issuing host and are cached for repeats.
// - Response timeout moves on to the next command; zero waits forever.
// - Unrequested serial data is discarded, sent to last or to all.
// - Nonzero length flushes at that count; zero uses delimiters or full.
// - First delimiter byte flushes the buffer when enabled.
// - Reaching one kilobyte always flushes, delimiters or not.
// - Post-process needs delimiter one; both enabled needs both bytes.
// - Delimiter action: now, after one, after two, or stripped.
// - Idle serial input longer than the gap flushes the buffer.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
module serial_net_forwarder #(
  parameter int MS_CYC = serial_net_pkg::MS_CYCLES,
  parameter int MIN_MS = serial_net_pkg::MIN_MS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial receive bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Packed stream to hosts
  output logic net_valid,
  output logic [7:0] net_data,
  output logic net_flush,
  output logic net_empty,
  output logic [1:0] net_strip,
  output logic [7:0] net_dest,
  input wire logic [7:0] host_busy,
  // Network data to the serial port
  input wire logic hd_valid,
  input wire logic [7:0] hd_data,
  output logic hd_ready,
  output logic ser_tx_valid,
  output logic [7:0] ser_tx_data,
  input wire logic ser_tx_ready,
  // Host sessions
  input wire logic open_req,
  input wire logic [2:0] open_host,
  input wire logic [7:0] host_close,
  input wire logic [7:0] alive_ack,
  output logic open_grant,
  output logic [7:0] conn,
  output logic [7:0] probe,
  output logic [7:0] drop,
  // Host port control
  input wire logic ctrl_valid,
  input wire logic [2:0] ctrl_host,
  input wire logic ctrl_rts,
  input wire logic ctrl_dtr,
  input wire logic [15:0] ctrl_param,
  output logic rts_out,
  output logic dtr_out,
  output logic [15:0] ser_param,
  // Command by command
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_host,
  input wire logic [15:0] cmd_code,
  output logic cmd_ready,
  output logic iss_valid,
  output logic [15:0] iss_code,
  input wire logic iss_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  output logic ans_valid,
  output logic [7:0] ans_mask,
  output logic [15:0] ans_data
);
  if (MS_CYC < 1 || MS_CYC > 65536 || MIN_MS < 1 || MIN_MS > 65536)
  begin : g_bad_time
    $error("serial_net_forwarder: time parameter out of range");
  end
  localparam logic [15:0] MS_LAST = 16'(MS_CYC - 1);
  localparam logic [15:0] MIN_LAST = 16'(MIN_MS - 1);
  typedef struct packed {
    logic [9:0] ctrl;
    logic [15:0] delim;
    logic [10:0] pkt_len;
    logic [15:0] gap;
    logic [6:0] alive;
    logic [15:0] respto;
    logic [3:0] maxconn;
    logic [15:0] serparam;
    logic [15:0] ms_cnt;
    logic [15:0] min_cnt;
    logic ms_tick;
    logic [7:0] conn;
    logic [7:0][6:0] miss;
    logic [7:0] probe;
    logic [7:0] drop;
    logic grant;
    logic rts;
    logic dtr;
    logic [15:0] host_param;
    logic pin_rts;
    logic pin_dtr;
    logic [15:0] sp;
    logic [7:0][2:0] q;
    logic [3:0] q_cnt;
    logic busy;
    logic [2:0] cur;
    logic [15:0] wait_ms;
    logic [2:0] last_req;
    logic [7:0] pend;
    logic [7:0][15:0] pend_code;
    logic [7:0] cache_vld;
    logic [7:0][15:0] cache_code;
    logic [7:0][15:0] cache_rsp;
    logic ans_valid;
    logic [7:0] ans_mask;
    logic [15:0] ans_data;
    logic st_valid;
    logic [7:0] st_data;
    logic [31:0] prdata;
    logic pslverr;
  } fwd_state_type;
  fwd_state_type s;
  fwd_state_type next_s;
  function automatic logic [7:0] onehot(input logic [2:0] h);
    onehot = 8'h01 << h;
  endfunction : onehot
  function automatic logic [3:0] ones(input logic [7:0] v);
    ones = 4'd0;
    for (int i = 0; i < 8; i++) ones = ones + 4'(v[i]);
  endfunction : ones
  pack_if pk();
  logic pk_ready;
  logic min_tick;
  logic [3:0] lim;
  logic multi;
  logic [3:0] qc;
  logic [2:0] h;
  assign pk.pkt_len = s.pkt_len;
  assign pk.d1 = s.delim[7:0];
  assign pk.d2 = s.delim[15:8];
  assign pk.d1_en = s.ctrl[serial_net_pkg::CTRL_D1EN];
  assign pk.d2_en = s.ctrl[serial_net_pkg::CTRL_D2EN];
  assign pk.proc =
    serial_net_pkg::delim_proc_type'(s.ctrl[serial_net_pkg::CTRL_PROC +: 2]);
  assign pk.gap_ms = s.gap;
  assign pk.ms_tick = s.ms_tick;
  serial_packer #(.BUF(serial_net_pkg::BUF_BYTES)) u_pack (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(pk),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ready(rx_ready),
    .out_valid(net_valid),
    .out_data(net_data),
    .out_flush(net_flush),
    .out_empty(net_empty),
    .out_strip(net_strip),
    .out_ready(pk_ready)
  );
  // Delivery to hosts: stall on any busy connected host, or skip busy ones
  assign net_dest = s.ctrl[serial_net_pkg::CTRL_JAM] ?
                    (s.conn & ~host_busy) : s.conn;
  assign pk_ready = s.ctrl[serial_net_pkg::CTRL_JAM] ||
                    ((s.conn & host_busy) == 8'h00);
  assign pready = 1'b1;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign hd_ready = !s.st_valid || ser_tx_ready;
  assign ser_tx_valid = s.st_valid;
  assign ser_tx_data = s.st_data;
  assign open_grant = s.grant;
  assign conn = s.conn;
  assign probe = s.probe;
  assign drop = s.drop;
  assign rts_out = s.pin_rts;
  assign dtr_out = s.pin_dtr;
  assign ser_param = s.sp;
  assign ans_valid = s.ans_valid;
  assign ans_mask = s.ans_mask;
  assign ans_data = s.ans_data;
  assign cmd_ready = s.ctrl[serial_net_pkg::CTRL_CMD] && s.conn[cmd_host] &&
                     !s.pend[cmd_host];
  assign iss_valid = s.ctrl[serial_net_pkg::CTRL_CMD] && !s.busy &&
                     s.q_cnt != 4'd0;
  assign iss_code = s.pend_code[s.q[0]];
  assign min_tick = s.ms_tick && s.min_cnt == MIN_LAST;
  assign lim = (s.maxconn == 4'd0) ? serial_net_pkg::MAXCONN_RST :
               (s.maxconn > serial_net_pkg::MAXCONN_TOP) ?
               serial_net_pkg::MAXCONN_TOP : s.maxconn;
  assign multi = lim > serial_net_pkg::MAXCONN_RST;
  always_comb begin
    next_s = s;
    qc = s.q_cnt;
    h = cmd_host;
    // Register bus: read data prepared in setup, writes in access
    if (psel && !penable) begin
      next_s.pslverr = 1'b0;
      case (paddr)
        serial_net_pkg::OFS_CTRL: next_s.prdata = 32'(s.ctrl);
        serial_net_pkg::OFS_DELIM: next_s.prdata = 32'(s.delim);
        serial_net_pkg::OFS_PKTLEN: next_s.prdata = 32'(s.pkt_len);
        serial_net_pkg::OFS_GAP: next_s.prdata = 32'(s.gap);
        serial_net_pkg::OFS_ALIVE: next_s.prdata = 32'(s.alive);
        serial_net_pkg::OFS_RESPTO: next_s.prdata = 32'(s.respto);
        serial_net_pkg::OFS_MAXCONN: next_s.prdata = 32'(s.maxconn);
        serial_net_pkg::OFS_SERPARAM: next_s.prdata = 32'(s.serparam);
        serial_net_pkg::OFS_STATUS:
          next_s.prdata = 32'({s.q_cnt, s.busy, s.conn});
        default: begin
          next_s.prdata = 32'h0000_0000;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pwrite) begin
      case (paddr)
        serial_net_pkg::OFS_CTRL:
          next_s.ctrl = pwdata[serial_net_pkg::CTRL_W-1:0];
        serial_net_pkg::OFS_DELIM: next_s.delim = pwdata[15:0];
        serial_net_pkg::OFS_PKTLEN:
          next_s.pkt_len = pwdata[serial_net_pkg::LEN_W-1:0];
        serial_net_pkg::OFS_GAP: next_s.gap = pwdata[15:0];
        serial_net_pkg::OFS_ALIVE:
          next_s.alive = pwdata[serial_net_pkg::ALIVE_W-1:0];
        serial_net_pkg::OFS_RESPTO: next_s.respto = pwdata[15:0];
        serial_net_pkg::OFS_MAXCONN:
          next_s.maxconn = pwdata[serial_net_pkg::CONN_W-1:0];
        serial_net_pkg::OFS_SERPARAM: next_s.serparam = pwdata[15:0];
        default: ;
      endcase
    end
    // Millisecond and minute ticks
    next_s.ms_tick = (s.ms_cnt == MS_LAST);
    next_s.ms_cnt = next_s.ms_tick ? 16'h0000 : s.ms_cnt + 16'd1;
    if (s.ms_tick) next_s.min_cnt = min_tick ? 16'h0000 : s.min_cnt + 16'd1;
    // Keep-alive supervision per host
    next_s.probe = 8'h00;
    next_s.drop = 8'h00;
    next_s.grant = 1'b0;
    for (int i = 0; i < serial_net_pkg::HOSTS; i++) begin
      if (s.conn[i]) begin
        if (alive_ack[i]) next_s.miss[i] = 7'd0;
        else if (min_tick && s.alive != 7'd0) begin
          next_s.probe[i] = 1'b1;
          next_s.miss[i] = s.miss[i] + 7'd1;
          if (s.miss[i] + 7'd1 >= s.alive) begin
            next_s.conn[i] = 1'b0;
            next_s.drop[i] = 1'b1;
          end
        end
        if (host_close[i]) next_s.conn[i] = 1'b0;
      end
    end
    // Admission into any free slot
    if (open_req && !s.conn[open_host] && ones(s.conn) < lim) begin
      next_s.conn[open_host] = 1'b1;
      next_s.miss[open_host] = 7'd0;
      next_s.grant = 1'b1;
    end
    // Port control from hosts
    if (ctrl_valid && s.conn[ctrl_host] &&
        (!multi || s.ctrl[serial_net_pkg::CTRL_HCTL])) begin
      next_s.rts = ctrl_rts;
      next_s.dtr = ctrl_dtr;
      next_s.host_param = ctrl_param;
    end
    next_s.sp = multi ? s.serparam : s.host_param;
    next_s.pin_rts = s.rts && !(s.ctrl[serial_net_pkg::CTRL_LDLOW] &&
                                s.conn == 8'h00);
    next_s.pin_dtr = s.dtr && !(s.ctrl[serial_net_pkg::CTRL_LDLOW] &&
                                s.conn == 8'h00);
    // Network to serial, one stage, in order
    if (ser_tx_ready) next_s.st_valid = 1'b0;
    if (hd_valid && hd_ready) begin
      next_s.st_valid = 1'b1;
      next_s.st_data = hd_data;
    end
    // Command by command: response, timeout, issue, accept
    next_s.ans_valid = 1'b0;
    if (rsp_valid && s.busy) begin
      next_s.ans_valid = 1'b1;
      next_s.ans_mask = onehot(s.cur);
      next_s.ans_data = rsp_data;
      next_s.cache_vld[s.cur] = 1'b1;
      next_s.cache_code[s.cur] = s.pend_code[s.cur];
      next_s.cache_rsp[s.cur] = rsp_data;
      next_s.pend[s.cur] = 1'b0;
      next_s.busy = 1'b0;
    end else if (rsp_valid) begin
      case (serial_net_pkg::unreq_type'(
              s.ctrl[serial_net_pkg::CTRL_UNREQ +: 2]))
        serial_net_pkg::UNREQ_LAST: begin
          next_s.ans_valid = 1'b1;
          next_s.ans_mask = onehot(s.last_req);
          next_s.ans_data = rsp_data;
        end
        serial_net_pkg::UNREQ_ALL: begin
          next_s.ans_valid = 1'b1;
          next_s.ans_mask = s.conn;
          next_s.ans_data = rsp_data;
        end
        default: ;
      endcase
    end else if (s.busy && s.respto != 16'h0000 && s.ms_tick) begin
      next_s.wait_ms = s.wait_ms + 16'd1;
      if (next_s.wait_ms >= s.respto) begin
        next_s.busy = 1'b0;
        next_s.pend[s.cur] = 1'b0;
      end
    end
    if (iss_valid && iss_ready) begin
      next_s.busy = 1'b1;
      next_s.cur = s.q[0];
      next_s.wait_ms = 16'h0000;
      for (int i = 0; i < serial_net_pkg::HOSTS - 1; i++)
        next_s.q[i] = s.q[i+1];
      qc = s.q_cnt - 4'd1;
    end
    if (cmd_valid && cmd_ready) begin
      next_s.last_req = h;
      if (!rsp_valid && s.cache_vld[h] && s.cache_code[h] == cmd_code) begin
        next_s.ans_valid = 1'b1;
        next_s.ans_mask = onehot(h);
        next_s.ans_data = s.cache_rsp[h];
      end else begin
        next_s.pend[h] = 1'b1;
        next_s.pend_code[h] = cmd_code;
        next_s.q[qc[2:0]] = h;
        qc = qc + 4'd1;
      end
    end
    next_s.q_cnt = qc;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.alive <= serial_net_pkg::ALIVE_RST;
      s.maxconn <= serial_net_pkg::MAXCONN_RST;
      s.rts <= 1'b1;
      s.dtr <= 1'b1;
      s.pin_rts <= 1'b1;
      s.pin_dtr <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_alive_off: assert property (s.alive == 7'd0 |=> s.probe == 8'h00)
    else $error("probe sent with alive check off");
  chk_alive_drop: assert property (
    min_tick && s.conn[0] && !alive_ack[0] && s.alive != 7'd0 &&
    s.miss[0] + 7'd1 >= s.alive |=> s.drop[0] && !s.conn[0])
    else $error("silent host not closed");
  chk_grant_limit: assert property (
    open_req && ones(s.conn) >= lim |=> !s.grant)
    else $error("admitted beyond the connection limit");
  chk_ctrl_ignore: assert property (
    ctrl_valid && multi && !s.ctrl[serial_net_pkg::CTRL_HCTL]
    |=> s.rts == $past(s.rts) && s.host_param == $past(s.host_param))
    else $error("control taken while disabled");
  chk_link_low: assert property (
    s.ctrl[serial_net_pkg::CTRL_LDLOW] && s.conn == 8'h00
    |=> !rts_out && !dtr_out)
    else $error("handshake lines not low on link loss");
  chk_busy_hold: assert property (s.busy && !rsp_valid &&
    s.respto == 16'h0000 |=> s.busy) else $error("busy dropped early");
  chk_resp_route: assert property (
    rsp_valid && s.busy |=> ans_valid && ans_mask == onehot($past(s.cur)))
    else $error("response not routed to requester");
  chk_jam_stall: assert property (
    !s.ctrl[serial_net_pkg::CTRL_JAM] && (s.conn & host_busy) != 8'h00
    && net_valid |=> net_valid && $stable(net_data))
    else $error("group sent while a host is busy");
  chk_fifo_order: assert property (
    hd_valid && hd_ready |=> ser_tx_valid && ser_tx_data == $past(hd_data))
    else $error("network byte not forwarded in order");
endmodule : serial_net_forwarder

// >>> tb/host_side_model.sv
// Far-side model: network hosts that answer keep-alive probes.
// Assumes probe pulses from the forwarder, synchronous to pclk.
`timescale 1ns/100ps
module host_side_model (
  // Clock
  input wire logic pclk,
  // Bench control
  input wire logic ack_en,
  input wire logic busy_en,
  // Forwarder side
  input wire logic [7:0] probe,
  output logic [7:0] alive_ack,
  output logic [7:0] host_busy
);
  // A host answers a probe one cycle later, only when acks are on
  always @(posedge pclk) begin
    alive_ack <= ack_en ? probe : 8'h00;
  end
  // All hosts share one serial setting, so only busy is modelled
  assign host_busy = busy_en ? 8'hff : 8'h00;
endmodule : host_side_model

// >>> tb/tb_top.sv
// Self-checking bench for the forwarder top.
// Assumes APB at 10 MHz and short ms and minute parameters.
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: value mismatch", $time); end end
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, rx_valid = 1'b0, hd_valid = 1'b0, open_req = 1'b0;
  logic ser_tx_ready = 1'b1, ctrl_valid = 1'b0, ctrl_rts = 1'b0;
  logic ctrl_dtr = 1'b0, cmd_valid = 1'b0, iss_ready = 1'b0;
  logic rsp_valid = 1'b0, ack_en = 1'b0, busy_en = 1'b0;
  logic [7:0] paddr = 8'h00, rx_data = 8'h00, hd_data = 8'h00;
  logic [7:0] host_close = 8'h00;
  logic [2:0] open_host = 3'h0, ctrl_host = 3'h0, cmd_host = 3'h0;
  logic [15:0] ctrl_param = 16'h0000, cmd_code = 16'h0000;
  logic [15:0] rsp_data = 16'h0000, ser_param, iss_code, ans_data;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, rx_ready, net_valid, net_flush, net_empty, er;
  logic hd_ready, ser_tx_valid, open_grant, rts_out, dtr_out, cmd_ready;
  logic iss_valid, ans_valid;
  logic [1:0] net_strip;
  logic [7:0] net_data, net_dest, ser_tx_data, conn, probe, drop, ans_mask;
  logic [7:0] alive_ack, host_busy, b;
  logic [15:0] c16, r16;
  int n_mismatch = 0, compares = 0;
  serial_net_forwarder #(.MS_CYC(4), .MIN_MS(3)) u_dut (.*);
  host_side_model u_host (.*);
  always #50 pclk = ~pclk;
  task wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  function logic last_beat(input int i, input int n);
    return i == n - 1;
  endfunction : last_beat
  // Sends n bytes, the last one given; checks each beat and its flush
  task pack(input int n, input logic [7:0] last, input logic [1:0] st,
            input logic fl);
    for (int i = 0; i < n; i++) begin
      b = last_beat(i, n) ? last : (8'($urandom) | 8'h80);
      @(posedge pclk);
      rx_valid <= 1'b1; rx_data <= b;
      do @(posedge pclk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
      #1;
      `CHK(net_data, b)
      `CHK(net_flush, last_beat(i, n) && fl)
      if (last_beat(i, n)) `CHK(net_strip, st)
    end
  endtask : pack
  initial begin
    #1_000_000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hbf4a));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, serial_net_pkg::OFS_ALIVE, 32'h0);
    `CHK(rd, 32'h0000_0007)
    apb(1'b0, serial_net_pkg::OFS_MAXCONN, 32'h0);
    `CHK(rd, 32'h0000_0001)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, serial_net_pkg::OFS_PKTLEN, 32'h0000_0003);
    pack(3, 8'($urandom) | 8'h80, 2'b00, 1'b1);
    apb(1'b1, serial_net_pkg::OFS_PKTLEN, 32'h0);
    apb(1'b1, serial_net_pkg::OFS_DELIM, 32'h0000_000d);
    apb(1'b1, serial_net_pkg::OFS_CTRL, 32'h0000_0100);
    pack(4, 8'h0d, 2'b00, 1'b1);
    apb(1'b1, serial_net_pkg::OFS_CTRL, 32'h0000_01c8);
    pack(2, 8'h0d, 2'b01, 1'b1);
    repeat (3) @(posedge pclk);
    `CHK(rts_out, 1'b0)
    `CHK(dtr_out, 1'b0)
    apb(1'b1, serial_net_pkg::OFS_DELIM, 32'h0000_0a0d);
    apb(1'b1, serial_net_pkg::OFS_CTRL, 32'h0000_0348);
    pack(2, 8'h0d, 2'b00, 1'b0);
    pack(1, 8'h0a, 2'b00, 1'b0);
    pack(1, 8'h81, 2'b00, 1'b1);
    apb(1'b1, serial_net_pkg::OFS_GAP, 32'h0000_0002);
    pack(1, 8'h81, 2'b00, 1'b0);
    for (int t = 0; t < 100 && net_empty !== 1'b1; t++) @(negedge pclk);
    `CHK(net_flush, 1'b1)
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      @(posedge pclk);
      hd_valid <= 1'b1; hd_data <= b;
      do @(posedge pclk); while (hd_ready !== 1'b1);
      hd_valid <= 1'b0;
      #1;
      `CHK(ser_tx_data, b)
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      open_req <= 1'b1; open_host <= 3'(2 + k);
      @(posedge pclk);
      open_req <= 1'b0;
      #1;
      `CHK(conn[2 + k], 1'b1)
      for (int t = 0; t < 300 && drop[2 + k] !== 1'b1; t++) @(posedge pclk);
      @(posedge pclk);
      #1;
      `CHK(conn[2 + k], 1'b0)
    end
    ack_en <= 1'b1;
    iss_ready <= 1'b1;
    apb(1'b1, serial_net_pkg::OFS_CTRL, 32'h0000_0019);
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      open_req <= 1'b1; open_host <= 3'(1 + 3 * k);
      @(posedge pclk);
      open_req <= 1'b0;
    end
    #1;
    `CHK(conn, 8'h02)
    `CHK(rts_out, 1'b1)
    c16 = 16'($urandom);
    r16 = 16'($urandom);
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      cmd_valid <= 1'b1; cmd_host <= 3'h1; cmd_code <= c16;
      do @(posedge pclk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      if (k == 0) begin
        @(negedge pclk);
        `CHK(iss_valid, 1'b1)
        `CHK(iss_code, c16)
        @(posedge pclk);
        rsp_valid <= 1'b1; rsp_data <= r16;
        @(posedge pclk);
        rsp_valid <= 1'b0;
      end
      #1;
      `CHK(iss_valid, 1'b0)
      `CHK(ans_valid, 1'b1)
      `CHK(ans_mask, 8'h02)
      `CHK(ans_data, r16)
    end
    r16 = 16'($urandom);
    @(posedge pclk);
    rsp_valid <= 1'b1; rsp_data <= r16;
    @(posedge pclk);
    rsp_valid <= 1'b0;
    #1;
    `CHK(ans_valid, 1'b1)
    `CHK(ans_mask, 8'h02)
    `CHK(ans_data, r16)
    busy_en <= 1'b1;
    pack(1, 8'h81, 2'b00, 1'b0);
    repeat (3) @(negedge pclk);
    `CHK(net_valid, 1'b1)
    `CHK(net_dest, 8'h02)
    apb(1'b1, serial_net_pkg::OFS_CTRL, 32'h0000_001b);
    @(negedge pclk);
    `CHK(net_dest, 8'h00)
    wrap_up();
  end
endmodule : tb_top
